/* File: uart_pkg.sv */
package uart_pkg;
	// Baud generator phase step per clock and lower divisor bound
	localparam logic [16:0] FRAC_STEP  = 17'h00040;
	localparam logic [15:0] BAUD_MIN   = 16'h0040;
	localparam int unsigned CLK_HZ     = 10_000_000;
	// Samples per bit in asynchronous reception
	localparam logic [4:0]  OVS_NORMAL = 5'h10;
	localparam logic [4:0]  OVS_DOUBLE = 5'h08;
	// Character size codes and data bit counts
	localparam logic [2:0]  CHSZ_MAX   = 3'h4;
	localparam logic [3:0]  DBITS_MIN  = 4'h5;
	localparam logic [3:0]  DBITS_MAX  = 4'h9;
	localparam int unsigned DATA_W     = 9;
	localparam int unsigned SHIFT_W    = 12;
	// Received word layout: status bits above the data
	localparam int unsigned STAT_FERR  = 9;
	localparam int unsigned STAT_PERR  = 10;
	localparam int unsigned STAT_OVF   = 11;
	localparam int unsigned RX_WORD_W  = 12;
	// Idle levels of the pins
	localparam logic        LINE_IDLE  = 1'b1;
	localparam logic        XCK_IDLE   = 1'b0;

	typedef enum logic [1:0]
	{
		TX_IDLE  = 2'h1,
		TX_SHIFT = 2'h2
	} tx_state_t;

	typedef enum logic [4:0]
	{
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} rx_state_t;
endpackage

/* File: stream_fifo.sv */
`timescale 1ns/1ps
module stream_fifo
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
)
(
	input  wire logic             clk,       // Clock
	input  wire logic             rst_n,     // Async reset, low
	input  wire logic [WIDTH-1:0] in_data,   // Word to store
	input  wire logic             in_valid,  // Word offered
	output logic                  in_ready,  // Room for a word
	output logic      [WIDTH-1:0] out_data,  // Oldest word
	output logic                  out_valid, // Oldest word present
	input  wire logic             out_ready  // Oldest word taken
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	// Pointers wrap naturally only for a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("stream_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;

	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;
	wire [AW:0]       next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	assign out_data = mem[rd_ptr];

	// Storage, written only on an accepted word
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers and registered full and empty
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			wr_ptr    <= wr_ptr + AW'(push);
			rd_ptr    <= rd_ptr + AW'(pop);
			count     <= next_count;
			in_ready  <= next_count != FULL_CNT;
			out_valid <= next_count != '0;
		end
	end

	AST_FIFO_FULL_REFUSES: assert property (@(posedge clk) disable iff (!rst_n)
		count == FULL_CNT |-> !in_ready && out_valid)
		else $error("fifo full but still ready");
endmodule

/* File: uart_core.sv */
`timescale 1ns/1ps
// Summary of operation
// - Asynchronous, synchronous, full and half duplex
// - Five to nine data bits, one/two stops
// - Odd or even parity made and checked
// - Overflow and framing errors detected, reported
// - Majority filter; false start bits rejected in async mode
// - Transmit complete, holding empty, receive complete
// - Two-level holding buffer, shifter, frame builder
// - Receive shifter feeds two-level buffer
// - Frames follow back to back when fed
// - Per-character status readable with data
// - Oversampled recovery locks to start edge
// - Fractional divisor from any clock rate
// - Shift clock pin driven or received
// - Driver enable high while transmitting
// - Transmit pin doubles as one-wire receive
// - Low start, data, parity, high stops
// - Writes accepted only while holding empty
// - Complete flag after last frame drains
module uart_core
	import uart_pkg::*;
#(
	parameter int unsigned TX_DEPTH = 2, // Transmit holding levels
	parameter int unsigned RX_DEPTH = 2  // Receive buffer levels
)
(
	input  wire logic                 clk,                          // 10 MHz clock
	input  wire logic                 rst_n,                        // Async reset, low
	input  wire logic [15:0]          baud_divisor_reg,             // Divisor, 6 fraction bits
	input  wire logic [2:0]           frame_format_reg,             // Character size code
	input  wire logic                 parity_en,                    // Parity bit present
	input  wire logic                 parity_odd,                   // Odd parity
	input  wire logic                 two_stop,                     // Two stop bits
	input  wire logic                 sync_mode,                    // Synchronous mode
	input  wire logic                 sync_master,                  // Drive the shift clock
	input  wire logic                 double_speed,                 // Eight samples per bit
	input  wire logic                 one_wire,                     // Receive on transmit pin
	input  wire logic                 rs485_en,                     // Driver enable output on
	input  wire logic [1:0]           tx_rx_enable_reg,             // Bit1 transmit, bit0 receive
	input  wire logic [DATA_W-1:0]    tx_data,                      // Character to send
	input  wire logic                 tx_valid,                     // Character offered
	output logic                      tx_holding_empty_flag,        // Holding room, write ready
	input  wire logic                 tx_complete_clr,              // Clear complete flag
	output logic                      tx_complete_flag,             // Transmission complete
	output logic [RX_WORD_W-1:0]      rx_word,                      // Status and character
	output logic                      rx_valid,                     // Reception complete
	input  wire logic                 rx_ready,                     // Character read
	input  wire logic                 rxd_in,                       // Receive pin
	input  wire logic                 txd_in,                       // Transmit pin level
	output logic                      txd_out,                      // Transmit pin drive
	output logic                      txd_oe_n,                     // Transmit pin enable, low
	input  wire logic                 sync_shift_clock_pin_in,      // Shift clock pin level
	output logic                      sync_shift_clock_pin_out,     // Shift clock pin drive
	output logic                      sync_shift_clock_pin_oe_n,    // Shift clock enable, low
	output logic                      line_driver_enable_out        // External driver enable
);
	if (TX_DEPTH < 2 || RX_DEPTH < 2)
	begin : g_bad_depth
		$error("uart_core buffers need at least two levels");
	end

	// Frame arithmetic; size and parity shared by both directions, mask for transmit only
	function automatic logic [3:0] data_bits(input logic [2:0] code);
		data_bits = (code > CHSZ_MAX) ? DBITS_MAX : 4'(code) + DBITS_MIN;
	endfunction

	function automatic logic [DATA_W-1:0] data_mask(input logic [DATA_W-1:0] d,
		input logic [3:0] n);
		data_mask = d & ~(9'h1FF << n);
	endfunction

	function automatic logic parity_of(input logic [DATA_W-1:0] d, input logic odd);
		parity_of = (^d) ^ odd;
	endfunction

	tx_state_t          tx_state;
	tx_state_t          next_tx_state;
	rx_state_t          rx_state;
	rx_state_t          next_rx_state;
	logic [16:0]        baud_acc;
	logic [4:0]         tx_ovs;
	logic [4:0]         rx_cnt;
	logic [3:0]         tx_left;
	logic [SHIFT_W-1:0] tx_sh;
	logic [3:0]         rx_left;
	logic [DATA_W-1:0]  rx_sh;
	logic               rx_par;
	logic [2:0]         rx_hist;
	logic               xck_in_d;
	logic               ovf_pend;
	logic [DATA_W-1:0]  tx_fifo_data;
	logic               tx_fifo_valid;
	logic               rx_fifo_ready;

	// Decoded configuration
	wire        tx_en   = tx_rx_enable_reg[1];
	wire        rx_en   = tx_rx_enable_reg[0];
	wire [3:0]  nbits   = data_bits(frame_format_reg);
	wire [4:0]  ovs     = double_speed ? OVS_DOUBLE : OVS_NORMAL;
	wire [4:0]  ovs_max = ovs - 5'h01;
	wire [4:0]  half    = (ovs >> 1) - 5'h01;

	// Fractional divisor; synchronous mode keeps only the integer part
	wire [15:0] baud_raw  = sync_mode ? {baud_divisor_reg[15:6], 6'h00} : baud_divisor_reg;
	wire [16:0] baud_lim  = {1'b0, (baud_raw < BAUD_MIN) ? BAUD_MIN : baud_raw};
	wire [16:0] acc_sum   = baud_acc + FRAC_STEP;
	wire        baud_tick = acc_sum >= baud_lim;
	wire [16:0] next_acc  = baud_tick ? acc_sum - baud_lim : acc_sum;

	// Shift clock edges, generated or taken from the pin
	wire master   = sync_mode & sync_master;
	wire xck_rise = master ? baud_tick & ~sync_shift_clock_pin_out
		: sync_shift_clock_pin_in & ~xck_in_d;
	wire xck_fall = master ? baud_tick & sync_shift_clock_pin_out
		: ~sync_shift_clock_pin_in & xck_in_d;

	// Accumulator and shift clock generation
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			baud_acc                 <= '0;
			xck_in_d                 <= XCK_IDLE;
			sync_shift_clock_pin_out <= XCK_IDLE;
		end
		else
		begin
			baud_acc                 <= next_acc;
			xck_in_d                 <= sync_shift_clock_pin_in;
			sync_shift_clock_pin_out <= master ? sync_shift_clock_pin_out ^ baud_tick
				: XCK_IDLE;
		end
	end

	// Bit boundaries of the transmitter
	wire tx_bit   = sync_mode ? xck_fall : baud_tick & (tx_ovs == ovs_max);
	wire tx_last  = (tx_state == TX_IDLE) | (tx_left == 4'h1);
	wire tx_load  = tx_bit & tx_last & tx_fifo_valid;
	wire tx_fin   = tx_bit & (tx_state == TX_SHIFT) & (tx_left == 4'h1) & ~tx_fifo_valid;

	// Transmit holding buffer; ready is the holding-empty flag
	stream_fifo
	#(
		.WIDTH (DATA_W),
		.DEPTH (TX_DEPTH)
	)
	u_tx_fifo
	(
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (tx_data),
		.in_valid  (tx_valid & tx_en),
		.in_ready  (tx_holding_empty_flag),
		.out_data  (tx_fifo_data),
		.out_valid (tx_fifo_valid),
		.out_ready (tx_load)
	);

	// Frame image behind the start bit: data, parity, stops
	wire [DATA_W-1:0]  tx_char  = data_mask(tx_fifo_data, nbits);
	wire [SHIFT_W-1:0] tx_base  = {3'h0, tx_char} | (12'hFFF << nbits);
	wire [SHIFT_W-1:0] tx_pbit  = 12'(parity_of(tx_char, parity_odd)) << nbits;
	wire [SHIFT_W-1:0] tx_frame = parity_en ? (tx_base & ~(12'h001 << nbits)) | tx_pbit
		: tx_base;
	wire [3:0]         tx_flen  = 4'h2 + nbits + 4'(parity_en) + 4'(two_stop);

	// Transmit sequencing
	always_comb
	begin
		next_tx_state = tx_state;
		case (tx_state)
			TX_IDLE:
				if (tx_load)
					next_tx_state = TX_SHIFT;
			TX_SHIFT:
				if (tx_fin)
					next_tx_state = TX_IDLE;
			default:
				next_tx_state = TX_IDLE;
		endcase
	end

	// Transmit shifter and pin
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state <= TX_IDLE;
			tx_ovs   <= '0;
			tx_left  <= '0;
			tx_sh    <= '1;
			txd_out  <= LINE_IDLE;
		end
		else
		begin
			tx_state <= next_tx_state;
			if (baud_tick)
				tx_ovs <= (tx_ovs == ovs_max) ? 5'h00 : tx_ovs + 5'h01;
			if (tx_load)
			begin
				txd_out <= 1'b0;
				tx_sh   <= tx_frame;
				tx_left <= tx_flen;
			end
			else if (tx_fin)
				txd_out <= LINE_IDLE;
			else if (tx_bit && tx_state == TX_SHIFT)
			begin
				txd_out <= tx_sh[0];
				tx_sh   <= {1'b1, tx_sh[SHIFT_W-1:1]};
				tx_left <= tx_left - 4'h1;
			end
		end
	end

	// Complete flag, pin enables and driver enable
	wire tx_busy_next = next_tx_state == TX_SHIFT;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_complete_flag          <= 1'b0;
			txd_oe_n                  <= 1'b1;
			line_driver_enable_out    <= 1'b0;
			sync_shift_clock_pin_oe_n <= 1'b1;
		end
		else
		begin
			if (tx_fin)
				tx_complete_flag <= 1'b1;
			else if (tx_complete_clr)
				tx_complete_flag <= 1'b0;
			txd_oe_n <= ~(one_wire ? tx_busy_next
				: tx_en | tx_busy_next | tx_fifo_valid);
			line_driver_enable_out    <= rs485_en & tx_busy_next;
			sync_shift_clock_pin_oe_n <= ~master;
		end
	end

	// Receive line choice and three-sample majority filter
	wire rx_line = one_wire ? txd_in : rxd_in;
	wire rx_filt = (rx_hist[0] & rx_hist[1]) | (rx_hist[1] & rx_hist[2])
		| (rx_hist[0] & rx_hist[2]);

	// Sample points: mid-bit in async, rising clock in sync
	wire [4:0] rx_target = (rx_state == RX_START) ? half : ovs_max;
	wire rx_sample = sync_mode ? xck_rise
		: baud_tick & (rx_cnt == rx_target) & (rx_state != RX_IDLE);
	wire start_det = rx_en & (rx_state == RX_IDLE) & ~rx_filt
		& (sync_mode ? xck_rise : baud_tick);
	wire enter_data = (start_det & sync_mode)
		| ((rx_state == RX_START) & rx_sample & ~rx_filt);
	wire rx_done = (rx_state == RX_STOP) & rx_sample;

	// Receive sequencing
	always_comb
	begin
		next_rx_state = rx_state;
		case (rx_state)
			RX_IDLE:
				if (start_det)
					next_rx_state = sync_mode ? RX_DATA : RX_START;
			RX_START:
				if (rx_sample)
					next_rx_state = rx_filt ? RX_IDLE : RX_DATA;
			RX_DATA:
				if (rx_sample && rx_left == 4'h1)
					next_rx_state = parity_en ? RX_PAR : RX_STOP;
			RX_PAR:
				if (rx_sample)
					next_rx_state = RX_STOP;
			RX_STOP:
				if (rx_sample)
					next_rx_state = RX_IDLE;
			default:
				next_rx_state = RX_IDLE;
		endcase
	end

	// Received character, parity and stop check
	wire [DATA_W-1:0]    rx_char = rx_sh >> (4'h9 - nbits);
	wire                 rx_perr = parity_en & (rx_par != parity_of(rx_char, parity_odd));
	wire [RX_WORD_W-1:0] rx_push = {ovf_pend, rx_perr, ~rx_filt, rx_char};

	// Receive shifter and overflow memory
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state <= RX_IDLE;
			rx_hist  <= {3{LINE_IDLE}};
			rx_cnt   <= '0;
			rx_left  <= '0;
			rx_sh    <= '0;
			rx_par   <= 1'b0;
			ovf_pend <= 1'b0;
		end
		else
		begin
			rx_state <= next_rx_state;
			rx_hist  <= {rx_hist[1:0], rx_line};
			if (start_det || rx_sample)
				rx_cnt <= '0;
			else if (baud_tick)
				rx_cnt <= rx_cnt + 5'h01;
			if (enter_data)
				rx_left <= nbits;
			else if (rx_sample && rx_state == RX_DATA)
			begin
				rx_sh   <= {rx_filt, rx_sh[DATA_W-1:1]};
				rx_left <= rx_left - 4'h1;
			end
			if (rx_sample && rx_state == RX_PAR)
				rx_par <= rx_filt;
			if (rx_done)
				ovf_pend <= ~rx_fifo_ready;
		end
	end

	// Receive buffer, status stored beside each character
	stream_fifo
	#(
		.WIDTH (RX_WORD_W),
		.DEPTH (RX_DEPTH)
	)
	u_rx_fifo
	(
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (rx_push),
		.in_valid  (rx_done),
		.in_ready  (rx_fifo_ready),
		.out_data  (rx_word),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_load;
		tx_load;
	endsequence

	sequence s_start_bit;
		!txd_out && tx_state == TX_SHIFT;
	endsequence

	AST_TX_START_LOW: assert property (s_load |=> s_start_bit)
		else $error("start bit not low after load");
	AST_TX_IDLE_HIGH: assert property (tx_state == TX_IDLE |-> txd_out)
		else $error("idle transmit line not high");
	AST_TXC_SET: assert property (tx_fin |=> tx_complete_flag)
		else $error("complete flag not set at frame end");
	AST_TXC_EARLY: assert property ($rose(tx_complete_flag) |-> $past(tx_fin))
		else $error("complete flag set without frame end");
	AST_B2B: assert property (tx_bit && tx_state == TX_SHIFT && tx_left == 4'h1
		&& tx_fifo_valid |=> s_start_bit)
		else $error("gap between queued frames");
	AST_FALSE_START: assert property (rx_state == RX_START && rx_sample && rx_filt
		|=> rx_state == RX_IDLE)
		else $error("false start bit accepted");
	AST_OVF_KEPT: assert property (rx_done && !rx_fifo_ready |=> ovf_pend)
		else $error("overflow not remembered");
	AST_FERR: assert property (rx_done && !rx_filt |-> rx_push[STAT_FERR])
		else $error("framing error not flagged");
	AST_DE: assert property (rs485_en && $past(rs485_en) && tx_state == TX_SHIFT
		|-> line_driver_enable_out)
		else $error("driver enable low during transmission");
	AST_XCK_DRIVE: assert property (master |=> !sync_shift_clock_pin_oe_n)
		else $error("shift clock not driven as master");
endmodule

/* File: remote_node.sv */
`timescale 1ns/1ps
module remote_node
#(
	parameter int unsigned BIT_CLKS = 16 // Clocks per bit
)
(
	input  wire logic       clk,      // Bench clock
	input  wire logic       line_in,  // Device transmit line level
	output logic            line_out, // Drives device receive pin
	input  wire logic [3:0] n_bits,   // Data bits per frame
	input  wire logic       par_en,   // Parity bit present
	input  wire logic       par_odd   // Odd parity
);
	logic [10:0] got_q[$];
	longint      start_q[$];
	longint      cyc = 0;
	logic [8:0]  sh;
	logic        pb;
	int          k;

	// Free cycle count, for frame spacing
	always @(posedge clk)
		cyc <= cyc + 1;

	// Receiver: mid-bit sampling, stores stop, parity and data
	initial
	begin
		forever
		begin
			@(posedge clk);
			if (line_in === 1'b0)
			begin
				repeat (BIT_CLKS / 2) @(posedge clk);
				if (line_in === 1'b0)
				begin
					start_q.push_back(cyc);
					sh = '0;
					for (k = 0; k < n_bits; k++)
					begin
						repeat (BIT_CLKS) @(posedge clk);
						sh[k] = line_in;
					end
					repeat (par_en ? BIT_CLKS : 0) @(posedge clk);
					pb = par_en & line_in;
					repeat (BIT_CLKS) @(posedge clk);
					got_q.push_back({line_in, pb, sh});
				end
			end
		end
	end

	// One bit held for a full bit period
	task automatic put_bit(input logic b);
		line_out <= b;
		repeat (BIT_CLKS) @(posedge clk);
	endtask

	// Whole frame, parity or stop may be spoiled on purpose
	task automatic send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
		logic [8:0] m;
		int         j;
		m = d & (9'h1FF >> (4'h9 - n_bits));
		@(posedge clk);
		put_bit(1'b0);
		for (j = 0; j < n_bits; j++)
			put_bit(m[j]);
		if (par_en)
			put_bit(^m ^ par_odd ^ bad_par);
		put_bit(~bad_stop);
		line_out <= 1'b1;
	endtask

	// Short low pulse that is no real start bit
	task automatic glitch(input int n);
		@(posedge clk);
		line_out <= 1'b0;
		repeat (n) @(posedge clk);
		line_out <= 1'b1;
	endtask

	initial
		line_out = 1'b1;
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	import uart_pkg::*;
	logic                 clk, rst_n, parity_en, parity_odd, two_stop, rs485_en, one_wire;
	logic [15:0]          baud_divisor_reg;
	logic [2:0]           frame_format_reg;
	logic [1:0]           tx_rx_enable_reg;
	logic [DATA_W-1:0]    tx_data;
	logic                 tx_valid, tx_complete_clr, rx_ready, rxd_in;
	logic                 tx_holding_empty_flag, tx_complete_flag, rx_valid;
	logic [RX_WORD_W-1:0] rx_word;
	logic                 txd_out, txd_oe_n, line_driver_enable_out;
	logic                 sync_shift_clock_pin_out, sync_shift_clock_pin_oe_n;
	int                   n_errors = 0, tests_run = 0, c, j, base, need;
	logic [8:0]           d[4], m;
	// Pull-up holds the line high when released
	wire                  txd_in = txd_oe_n ? LINE_IDLE : txd_out;
	wire [3:0]            nb = 4'(frame_format_reg) + DBITS_MIN;

	uart_core i_uart_core (.clk, .rst_n, .baud_divisor_reg, .frame_format_reg, .parity_en,
		.parity_odd, .two_stop, .sync_mode(1'b0), .sync_master(1'b0), .double_speed(1'b0),
		.one_wire, .rs485_en, .tx_rx_enable_reg, .tx_data, .tx_valid,
		.tx_holding_empty_flag, .tx_complete_clr, .tx_complete_flag, .rx_word, .rx_valid,
		.rx_ready, .rxd_in, .txd_in, .txd_out, .txd_oe_n, .sync_shift_clock_pin_in(1'b0),
		.sync_shift_clock_pin_out, .sync_shift_clock_pin_oe_n, .line_driver_enable_out);
	remote_node i_remote_node (.clk, .line_in(txd_in), .line_out(rxd_in), .n_bits(nb),
		.par_en(parity_en), .par_odd(parity_odd));

	// Bench clock, 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Verdict and end of run
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic fail(input string what);
		n_errors++;
		$display("BAD %s expected 1 seen 0", what);
		test_done();
	endtask

	function automatic bit ok(input int k);
		case (k)
			0: return rx_valid === 1'b1;
			1: return tx_complete_flag === 1'b1;
			2: return i_remote_node.got_q.size() >= need;
			default: return txd_in === 1'b0;
		endcase
	endfunction

	// Bounded wait on one of the conditions above
	task automatic wait_for(input int k, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			@(posedge clk);
			if (ok(k))
				return;
		end
		fail("wait condition");
	endtask

	// Offer a character until the holding buffer takes it
	task automatic put(input logic [8:0] v);
		int i;
		tx_data  <= v;
		tx_valid <= 1'b1;
		for (i = 0; i < 500; i++)
		begin
			@(posedge clk);
			if (tx_holding_empty_flag === 1'b1)
				return;
		end
		fail("write taken");
	endtask

	task automatic pop_check(input string what, input logic [11:0] exp);
		wait_for(0, 1000);
		check(what, rx_word, exp);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask

	function automatic logic [8:0] msk();
		return 9'h1FF >> (4'h9 - nb);
	endfunction

	function automatic logic [11:0] frame_clks();
		return 12'((2 + nb + parity_en + two_stop) * 16);
	endfunction

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		baud_divisor_reg = 16'h0040;
		{frame_format_reg, parity_en, parity_odd, two_stop, rs485_en, one_wire} = '0;
		{tx_rx_enable_reg, tx_data, tx_valid, tx_complete_clr, rx_ready} = '0;
		void'($urandom(66));
		repeat (6) @(posedge clk);
		check("reset outputs", {tx_holding_empty_flag, tx_complete_flag, rx_valid, txd_out,
			txd_oe_n, line_driver_enable_out, sync_shift_clock_pin_out,
			sync_shift_clock_pin_oe_n}, 12'h099);
		rst_n <= 1'b1;
		@(posedge clk);
		frame_format_reg <= 3'h3;
		@(posedge clk);
		tx_rx_enable_reg <= 2'h3;
		for (c = 0; c < 10; c++)
		begin
			@(posedge clk);
			frame_format_reg <= 3'(c % 5);
			{parity_en, parity_odd, two_stop, rs485_en} <= 4'($urandom);
			tx_complete_clr <= 1'b1;
			@(posedge clk);
			tx_complete_clr <= 1'b0;
			base = i_remote_node.got_q.size();
			need = base + 3;
			m = msk();
			for (j = 0; j < 3; j++)
			begin
				d[j] = 9'($urandom);
				put(d[j]);
			end
			tx_valid <= 1'b0;
			wait_for(3, 100);
			check("driver enable", {line_driver_enable_out, txd_oe_n}, {rs485_en, 1'b0});
			check("complete early", tx_complete_flag, 1'b0);
			wait_for(2, 3000);
			for (j = 0; j < 3; j++)
				check("tx frame", i_remote_node.got_q[base + j],
					{1'b1, parity_en & (^(d[j] & m) ^ parity_odd), d[j] & m});
			for (j = 0; j < 2; j++)
				check("frame gap", 12'(i_remote_node.start_q[base + j + 1] -
					i_remote_node.start_q[base + j]), frame_clks());
			wait_for(1, 100);
			d[0] = 9'($urandom);
			i_remote_node.send(d[0], 1'b0, 1'b0);
			pop_check("rx char", {3'h0, d[0] & m});
		end
		@(posedge clk);
		parity_en <= 1'b1;
		frame_format_reg <= 3'h3;
		for (j = 0; j < 4; j++)
			d[j] = 9'($urandom) & 9'h0FF;
		i_remote_node.send(d[0], 1'b1, 1'b0);
		pop_check("parity error", {3'h2, d[0]});
		i_remote_node.send(d[1], 1'b0, 1'b1);
		pop_check("framing error", {3'h1, d[1]});
		for (j = 0; j < 3; j++)
			i_remote_node.send(d[j], 1'b0, 1'b0);
		pop_check("first kept", {3'h0, d[0]});
		pop_check("second kept", {3'h0, d[1]});
		i_remote_node.send(d[3], 1'b0, 1'b0);
		pop_check("overflow mark", {3'h4, d[3]});
		i_remote_node.glitch(4);
		repeat (400) @(posedge clk);
		check("false start", rx_valid, 1'b0);
		// One-wire: pin released while idle, own frame echoed back
		one_wire <= 1'b1;
		repeat (2) @(posedge clk);
		check("one wire idle", txd_oe_n, 1'b1);
		d[0] = 9'($urandom) & 9'h0FF;
		put(d[0]);
		tx_valid <= 1'b0;
		pop_check("one wire echo", {3'h0, d[0]});
		one_wire <= 1'b0;
		tx_rx_enable_reg <= 2'h1;
		need = i_remote_node.got_q.size();
		tx_data <= 9'h0A5;
		tx_valid <= 1'b1;
		repeat (300) @(posedge clk);
		check("disabled tx", {12'(i_remote_node.got_q.size()), txd_oe_n},
			{12'(need), 1'b1});
		tx_valid <= 1'b0;
		tx_rx_enable_reg <= 2'h3;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check("mid reset", {tx_holding_empty_flag, tx_complete_flag, rx_valid, txd_out,
			txd_oe_n, line_driver_enable_out, sync_shift_clock_pin_out,
			sync_shift_clock_pin_oe_n}, 12'h099);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check("after release", {tx_holding_empty_flag, tx_complete_flag, rx_valid, txd_out,
			txd_oe_n, line_driver_enable_out, sync_shift_clock_pin_out,
			sync_shift_clock_pin_oe_n}, 12'h091);
		test_done();
	end
endmodule
